// *** bench/rtiu_props.sv ***
// Properties of the return instruction unit
`timescale 1ns/1ns
module rtiu_props(
    input wire core_clk, arst_n, clk_en, op_valid, ctrl_wr,
    input wire [13:0] op_word,
    input wire [12:0] top_of_stack, pc_q,
    input wire [2:0] stack_ptr, stack_ptr_q,
    input wire [7:0] ctrl_wdata, w_q, interrupt_control_reg_q,
    input wire pc_load_q, stack_pop_q, w_load_q, fetch_flush_q, busy_q);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    wire tk = clk_en && op_valid && !busy_q;
    wire fie = tk && op_word == 14'h0009;
    wire lit = tk && (op_word & 14'h3c00) == 14'h3400;
    a_fie_pc_load: assert property (fie |=> pc_load_q && pc_q == $past(top_of_stack))
        else $error("pc not loaded on interrupt return");
    a_fie_gie_set: assert property (fie |=> interrupt_control_reg_q[7])
        else $error("interrupt enable not set");
    a_fie_two_cycles: assert property (fie |=> busy_q ##1 !busy_q)
        else $error("interrupt return not two cycles");
    a_lit_w_load: assert property (lit |=> w_load_q && w_q == $past(op_word[7:0]))
        else $error("literal not in working register");
    a_lit_pc_pop: assert property (lit |=> stack_pop_q && pc_q == $past(top_of_stack))
        else $error("pc not loaded on literal return");
    a_lit_flush_cycles: assert property (lit |=> fetch_flush_q && busy_q ##1 !busy_q)
        else $error("literal return not two cycles");
    a_pop_ptr_dec: assert property (stack_pop_q |-> stack_ptr_q == $past(stack_ptr) - 3'h1)
        else $error("stack pointer not moved back");
    a_busy_refuse_op: assert property (clk_en && busy_q |=> !pc_load_q && !busy_q)
        else $error("op taken while busy");
    a_flush_one_pulse: assert property (clk_en && fetch_flush_q |=> !fetch_flush_q)
        else $error("refill pulse too long");
    a_freeze_holds: assert property (!clk_en |=> $stable(pc_q) && $stable(interrupt_control_reg_q))
        else $error("state moved while frozen");
endmodule
bind rtiu_return_unit rtiu_props rtiu_props_inst(.*);

// *** bench/tb_top.sv ***
// Bench for the return instruction unit
`timescale 1ns/1ns
module tb_top;
    reg core_clk = 0, arst_n = 0, clk_en = 1, op_valid = 0, ctrl_wr = 0;
    reg [13:0] op_word = 0;
    reg [12:0] top_of_stack = 0;
    reg [2:0] stack_ptr = 0;
    reg [7:0] ctrl_wdata = 0;
    wire [12:0] pc_q;
    wire [2:0] stack_ptr_q;
    wire [7:0] w_q, interrupt_control_reg_q;
    wire pc_load_q, stack_pop_q, w_load_q, fetch_flush_q, busy_q;
    integer fail_count = 0, total_checks = 0, i;
    reg [53:0] rows [0:3];
    rtiu_return_unit rtiu_return_unit_inst(.*);
    initial forever #20 core_clk = ~core_clk;
    task chk(input [31:0] got, input [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task summarize;
        $display("checks %0d errors %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task step;
        @(posedge core_clk);
        #1;
    endtask
    initial begin
        #100000;
        fail_count++;
        summarize;
    end
    initial begin
        // Opcode, stack top, pointer; then pc, working reg, pointer expected
        rows[0] = {14'h34ff, 13'h0123, 3'h0, 13'h0123, 8'hff, 3'h7};
        rows[1] = {14'h0009, 13'h0abc, 3'h5, 13'h0abc, 8'hff, 3'h4};
        rows[2] = {14'h3700, 13'h1fff, 3'h1, 13'h1fff, 8'h00, 3'h0};
        rows[3] = {14'h0009, 13'h0000, 3'h3, 13'h0000, 8'h00, 3'h2};
        repeat (10) step;
        arst_n = 1;
        chk({pc_q, w_q, interrupt_control_reg_q}, 0);
        step;
        ctrl_wr = 1;
        ctrl_wdata = 8'h55;
        step;
        ctrl_wr = 0;
        chk(interrupt_control_reg_q, 8'h55);
        // Op held during busy cycle so the refusal is exercised too
        for (i = 0; i < 4; i++) begin
            {op_word, top_of_stack, stack_ptr} = rows[i][53:24];
            op_valid = 1;
            step;
            chk({pc_q, w_q, stack_ptr_q, busy_q}, {rows[i][23:0], 1'b1});
            chk({pc_load_q, stack_pop_q, fetch_flush_q, w_load_q}, {3'b111, op_word[13:12] == 2'b11});
            step;
            chk(busy_q, 0);
        end
        chk(interrupt_control_reg_q, 8'hd5);
        op_word = 14'h0008;
        step;
        chk({pc_load_q, w_load_q, stack_pop_q, busy_q}, 0);
        // Frozen enable: op and write both ignored
        clk_en = 0;
        op_word = 14'h0009;
        ctrl_wr = 1;
        ctrl_wdata = 8'h00;
        step;
        chk({pc_load_q, busy_q, interrupt_control_reg_q}, {2'b00, 8'hd5});
        clk_en = 1;
        step;
        ctrl_wr = 0;
        chk(interrupt_control_reg_q, 8'h80);
        chk({fetch_flush_q, busy_q}, 2'b11);
        step;
        op_valid = 0;
        chk({fetch_flush_q, busy_q}, 0);
        // Reset in mid-run
        arst_n = 0;
        #1;
        chk({pc_q, w_q, interrupt_control_reg_q, busy_q}, 0);
        step;
        arst_n = 1;
        step;
        chk({pc_q, stack_ptr_q, interrupt_control_reg_q, busy_q}, 0);
        summarize;
    end
endmodule

// *** core/rtiu_consts.vh ***
// Constants for the return instruction unit
`ifndef RTIU_CONSTS_VH
`define RTIU_CONSTS_VH
`define RTIU_OP_W 14
`define RTIU_PC_W 13
`define RTIU_LIT_W 8
`define RTIU_SP_W 3
`define RTIU_RFI_CODE 14'h0009
`define RTIU_RLW_MASK 14'h3c00
`define RTIU_RLW_CODE 14'h3400
`define RTIU_IE_BIT 7
`define RTIU_CTRL_RST 8'h00
`define RTIU_W_RST 8'h00
`define RTIU_PC_RST 13'h0000
`define RTIU_SP_RST 3'h0
`define RTIU_SP_ONE 3'h1
`endif

// *** core/rtiu_return_unit.v ***
// Return instruction unit: return from interrupt and return with literal
//
// Behaviour
// - Return from interrupt pops stack, top of stack goes to program counter.
// - Return from interrupt sets global interrupt enable, bit 7 of control reg.
// - Return from interrupt: one word, two cycles, status flags untouched.
// - Return with literal loads its 8-bit immediate into working register, flags kept.
// - Return with literal pops stack into program counter.
// - Return with literal: one word, two cycles, second cycle refills fetch.
`timescale 1ns/1ns
`include "rtiu_consts.vh"
module rtiu_return_unit #(
    parameter OP_W = `RTIU_OP_W,
    parameter PC_W = `RTIU_PC_W,
    parameter SP_W = `RTIU_SP_W
) (
    // Clock and reset
    input wire core_clk,
    input wire arst_n,
    input wire clk_en,
    // Decoded instruction
    input wire op_valid,
    input wire [OP_W-1:0] op_word,
    // Call stack
    input wire [PC_W-1:0] top_of_stack,
    input wire [SP_W-1:0] stack_ptr,
    // Control register write from elsewhere in the core
    input wire ctrl_wr,
    input wire [`RTIU_LIT_W-1:0] ctrl_wdata,
    // Results
    output reg [PC_W-1:0] pc_q,
    output reg pc_load_q,
    output reg [SP_W-1:0] stack_ptr_q,
    output reg stack_pop_q,
    output reg [`RTIU_LIT_W-1:0] w_q,
    output reg w_load_q,
    output reg [`RTIU_LIT_W-1:0] interrupt_control_reg_q,
    output reg fetch_flush_q,
    output reg busy_q
);
    // One-hot sequencer states
    localparam ST_IDLE = 2'b01;
    localparam ST_REFILL = 2'b10;
    localparam LIT_W = `RTIU_LIT_W;

    // Sequencer
    reg [1:0] state_q;
    reg [1:0] state_d;

    // Next values of the registered outputs
    reg [PC_W-1:0] pc_d;
    reg pc_load_d;
    reg [SP_W-1:0] stack_ptr_d;
    reg stack_pop_d;
    reg [LIT_W-1:0] w_d;
    reg w_load_d;
    reg fetch_flush_d;
    reg busy_d;
    wire [LIT_W-1:0] ctrl_d;

    // Decode
    wire is_rfi;
    wire is_rlw;
    wire idle;
    wire go;
    wire go_rfi;
    wire go_rlw;
    wire [LIT_W-1:0] literal;

    assign is_rfi = (op_word == `RTIU_RFI_CODE);
    assign is_rlw = ((op_word & `RTIU_RLW_MASK) == `RTIU_RLW_CODE);
    assign idle = (state_q == ST_IDLE);

    // Opcode only accepted in idle; the refill cycle swallows the fetched word
    assign go = op_valid && idle && (is_rfi || is_rlw);
    assign go_rfi = go && is_rfi;
    assign go_rlw = go && is_rlw;

    // Immediate sits in the low byte of the word
    assign literal = op_word[LIT_W-1:0];

    // Sequencer next state
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (go) begin
                    state_d = ST_REFILL;
                end
            end
            ST_REFILL: begin
                // Second cycle: fetched word is discarded
                state_d = ST_IDLE;
            end
            default: begin
                // Recover from an illegal code without a reset
                state_d = ST_IDLE;
            end
        endcase
    end

    // Program counter load
    always @* begin
        pc_d = pc_q;
        pc_load_d = 1'b0;
        if (go) begin
            pc_d = top_of_stack;
            pc_load_d = 1'b1;
        end
    end

    // Stack pop; the stack memory itself lives outside this block
    always @* begin
        stack_ptr_d = stack_ptr_q;
        stack_pop_d = 1'b0;
        if (go) begin
            // Wraps below zero, as the stack is circular
            stack_ptr_d = stack_ptr - `RTIU_SP_ONE;
            stack_pop_d = 1'b1;
        end
    end

    // Working register load, literal returns only
    always @* begin
        w_d = w_q;
        w_load_d = 1'b0;
        if (go_rlw) begin
            w_d = literal;
            w_load_d = 1'b1;
        end
    end

    // Refill pulse and busy flag
    always @* begin
        fetch_flush_d = go;
        busy_d = go;
    end

    // Control register, one bit at a time
    genvar b;
    generate
        for (b = 0; b < LIT_W; b = b + 1) begin : g_ctrl_bit
            if (b == `RTIU_IE_BIT) begin : g_enable
                // Set wins over a concurrent write of zero
                assign ctrl_d[b] = go_rfi ? 1'b1 :
                    (ctrl_wr ? ctrl_wdata[b] : interrupt_control_reg_q[b]);
            end else begin : g_plain
                assign ctrl_d[b] = ctrl_wr ? ctrl_wdata[b] : interrupt_control_reg_q[b];
            end
        end
    endgenerate

    // Flags never touched here: no status output exists

    // Sequencer state register
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= ST_IDLE;
        end else if (clk_en) begin
            state_q <= state_d;
        end
    end

    // Program counter registers
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pc_q <= `RTIU_PC_RST;
            pc_load_q <= 1'b0;
        end else if (clk_en) begin
            pc_q <= pc_d;
            pc_load_q <= pc_load_d;
        end
    end

    // Stack registers
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            stack_ptr_q <= `RTIU_SP_RST;
            stack_pop_q <= 1'b0;
        end else if (clk_en) begin
            stack_ptr_q <= stack_ptr_d;
            stack_pop_q <= stack_pop_d;
        end
    end

    // Working register
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            w_q <= `RTIU_W_RST;
            w_load_q <= 1'b0;
        end else if (clk_en) begin
            w_q <= w_d;
            w_load_q <= w_load_d;
        end
    end

    // Control register
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            interrupt_control_reg_q <= `RTIU_CTRL_RST;
        end else if (clk_en) begin
            interrupt_control_reg_q <= ctrl_d;
        end
    end

    // Refill and busy; pulses hold while the clock enable is low
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            fetch_flush_q <= 1'b0;
            busy_q <= 1'b0;
        end else if (clk_en) begin
            fetch_flush_q <= fetch_flush_d;
            busy_q <= busy_d;
        end
    end
endmodule
